// File: design/hswdt_pkg.sv
// Package for the watchdog block: register offsets, field layout, codes,
// reset values and the structs that carry tick and source-clear groups.
// Assumes a Wishbone classic slave with 8-bit data in the low byte lane.
package hswdt_pkg;

  // Register byte addresses (index times four, printed offsets are not all word aligned)
  localparam logic [13:0] HSWDT_IDX_CONTROL = 14'h000C; // Control register index
  localparam logic [13:0] HSWDT_IDX_ID_HIGH = 14'h0FEB; // Selection ID high index
  localparam logic [13:0] HSWDT_IDX_ID_LOW = 14'h0FEC; // Selection ID low index
  localparam logic [15:0] HSWDT_ADR_CONTROL = {HSWDT_IDX_CONTROL, 2'h0};
  localparam logic [15:0] HSWDT_ADR_ID_HIGH = {HSWDT_IDX_ID_HIGH, 2'h0};
  localparam logic [15:0] HSWDT_ADR_ID_LOW = {HSWDT_IDX_ID_LOW, 2'h0};

  // Control register field positions
  localparam int HSWDT_POS_CS_HI = 7; // Clock select high bit
  localparam int HSWDT_POS_CS_LO = 6; // Clock select low bit
  localparam int HSWDT_POS_SUBRC = 5; // Sub-RC pick bit
  localparam int HSWDT_POS_HWFLAG = 4; // Hardware activation flag

  // Guard code that starts and clears the counter
  localparam logic [3:0] HSWDT_GUARD_CODE = 4'h5;

  // Selection ID values
  localparam logic [15:0] HSWDT_ID_STANDBY_OFF = 16'hA597; // Hardware, halted in standby
  localparam logic [15:0] HSWDT_ID_SOFTWARE = 16'hA596; // Software started mode

  // Reset values of the writable control fields
  localparam logic [2:0] HSWDT_SEL_RESET = 3'h0;
  localparam logic [2:0] HSWDT_SEL_HW_FIXED = 3'h1; // Clock selects 00, sub-RC pick 1

  // Tick source encodings of {clock_select_hi, clock_select_lo, subrc_pick}
  localparam logic [2:0] HSWDT_SEL_TB21 = 3'h0;
  localparam logic [2:0] HSWDT_SEL_TB20 = 3'h2;
  localparam logic [2:0] HSWDT_SEL_WP14 = 3'h4;
  localparam logic [2:0] HSWDT_SEL_WP13 = 3'h6;

  // Cycles that the reset request is held
  localparam logic [3:0] HSWDT_RST_PULSE_CYC = 4'h8;

  // Tick and source-clear inputs of the neighbouring timers
  typedef struct packed {
    logic tb21; // Timebase tap main clock / 2^21
    logic tb20; // Timebase tap main clock / 2^20
    logic wp14; // Watch prescaler tap subclock / 2^14
    logic wp13; // Watch prescaler tap subclock / 2^13
    logic rc16; // Sub-RC timer tap sub-RC clock / 2^16
  } hswdt_tick_t;

  typedef struct packed {
    logic timebase; // Timebase counter cleared
    logic prescaler; // Watch prescaler cleared
    logic subrc; // Sub-RC timer cleared
  } hswdt_srcclr_t;

  // Activation mode latched after reset
  typedef enum logic [1:0] {
    HSWDT_MODE_SW = 2'b00, // Software started
    HSWDT_MODE_HW_ALL = 2'b01, // Hardware, runs in standby too
    HSWDT_MODE_HW_NOSTBY = 2'b10 // Hardware, halted in standby
  } hswdt_mode_t;

endpackage : hswdt_pkg

// File: design/hswdt_tick_sel.sv
// Tick selector and rising-edge detector for the watchdog counter.
// Assumes the tap inputs are already synchronised to clock.
`timescale 1ns/100ps
`default_nettype none
module hswdt_tick_sel
  import hswdt_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire hswdt_tick_t taps, // Synchronised taps
  input wire hswdt_srcclr_t src_clr, // Synchronised source clears
  input wire logic [2:0] sel, // {cs_hi, cs_lo, subrc_pick}
  output logic tick, // One pulse per selected tap rise
  output logic clr // Selected source was cleared
);
  logic level; // Selected tap level
  logic prev_q; // Previous level
  logic prev_d;

  // Source mux; sub-RC pick overrides the clock select bits
  always_comb begin
    if (sel[0]) begin
      level = taps.rc16;
      clr = src_clr.subrc;
    end else begin
      unique case (sel[2:1])
        2'b00: begin
          level = taps.tb21;
          clr = src_clr.timebase;
        end
        2'b01: begin
          level = taps.tb20;
          clr = src_clr.timebase;
        end
        2'b10: begin
          level = taps.wp14;
          clr = src_clr.prescaler;
        end
        2'b11: begin
          level = taps.wp13;
          clr = src_clr.prescaler;
        end
      endcase
    end
    // History takes the muxed level only after the mux has settled
    prev_d = level;
    tick = level & ~prev_q;
  end

  // Edge detector history
  always_ff @(posedge clock) begin
    if (srst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule : hswdt_tick_sel
`default_nettype wire

// File: design/hswdt_top.sv
// Watchdog top: Wishbone classic register slave, activation logic,
// one-bit overflow counter and watchdog reset request.
// Assumes taps, source clears, standby and selection IDs arrive from
// other timing domains or pins and are resynchronised here.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Overflow raises the system reset request
// - One-bit counter; second tick after clear overflows
// - Reset falls one to two tick periods
// - Codes 000/010 pick timebase 2^21/2^20
// - Codes 100/110 pick prescaler 2^14/2^13
// - Sub-RC pick one forces sub-RC tap
// - Hardware IDs start counting at reset release
// - Hardware IDs choose standby halt or run
// - Hardware mode reads selects 00, pick 1
// - Flag reads one while hardware watchdog runs
// - First 0101 starts; only reset stops
// - Later 0101 clears; hardware any 0101 clears
// - A597 standby-halt, others except A596 always
// - Standby clears and stops unless configured running
module hswdt_top
  import hswdt_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Neighbouring timers and power control
  input wire hswdt_tick_t tick_taps,
  input wire hswdt_srcclr_t source_clear,
  input wire logic standby,
  input wire logic [7:0] select_id_high,
  input wire logic [7:0] select_id_low,
  // Watchdog reset request to the reset distribution
  output logic watchdog_reset
);

  // Two-flop synchronisers for taps, source clears, standby and selection ID
  localparam int SYNC_W = 5 + 3 + 1 + 16;
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  hswdt_tick_t taps_s; // Synchronised taps
  hswdt_srcclr_t srcclr_s; // Synchronised source clears
  logic standby_s; // Synchronised standby
  logic [15:0] id_s; // Synchronised selection ID

  assign sync_raw = {tick_taps, source_clear, standby, select_id_high, select_id_low};
  assign {taps_s, srcclr_s, standby_s, id_s} = sync2_q;

  // Synchroniser chain; first stage read only by second.
  // Kept out of srst so the selection ID has settled by reset release;
  // the mode latch at the first edge after release then sees the real ID.
  always_ff @(posedge clock) begin
    sync1_q <= sync_raw;
    sync2_q <= sync1_q;
  end

  // Mode and control state
  hswdt_mode_t mode_q, mode_d; // Activation mode
  logic loaded_q, loaded_d; // Mode sampled after reset
  logic [2:0] sel_q, sel_d; // {cs_hi, cs_lo, subrc_pick}
  logic started_q, started_d; // Software watchdog started
  logic cnt_q, cnt_d; // One-bit counter
  logic [3:0] rst_cnt_q, rst_cnt_d; // Reset pulse stretch
  logic rst_q, rst_d; // Watchdog reset output
  logic ack_q, ack_d; // Bus acknowledge
  logic [31:0] dat_q, dat_d; // Bus read data

  // Tick selection
  logic tick; // Selected tap edge
  logic src_clr; // Selected source cleared
  logic [2:0] eff_sel; // Select seen by the counter

  // Hardware mode fixes the source to sub-RC
  assign eff_sel = (mode_q == HSWDT_MODE_SW) ? sel_q : HSWDT_SEL_HW_FIXED;

  hswdt_tick_sel u_tick_sel (
    .clock(clock),
    .srst(srst),
    .taps(taps_s),
    .src_clr(srcclr_s),
    .sel(eff_sel),
    .tick(tick),
    .clr(src_clr)
  );

  // Bus decode
  logic req; // New request this cycle
  logic wr_ctl; // Write to control byte lane
  logic guard_hit; // Guard code written
  logic running; // Counter allowed to advance
  logic hw_mode; // Hardware activation
  logic stby_halt; // Standby halts the counter
  logic [7:0] ctl_rd; // Control read image

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_ctl = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == HSWDT_ADR_CONTROL);
  assign guard_hit = wr_ctl & (wb_dat_i[3:0] == HSWDT_GUARD_CODE);
  assign hw_mode = (mode_q != HSWDT_MODE_SW);
  assign stby_halt = standby_s & (mode_q != HSWDT_MODE_HW_ALL);
  assign running = loaded_q & (hw_mode | started_q);
  assign ctl_rd = {eff_sel, hw_mode, 4'h0};

  // Next state: mode sampling, software start, counter, reset, bus
  always_comb begin
    mode_d = mode_q;
    loaded_d = 1'b1;
    sel_d = sel_q;
    started_d = started_q;
    cnt_d = cnt_q;
    rst_cnt_d = rst_cnt_q;
    rst_d = rst_q;
    ack_d = req;
    dat_d = dat_q;
    // Mode caught once after reset release from the settled ID
    if (!loaded_q) begin
      if (id_s == HSWDT_ID_SOFTWARE) begin
        mode_d = HSWDT_MODE_SW;
      end else if (id_s == HSWDT_ID_STANDBY_OFF) begin
        mode_d = HSWDT_MODE_HW_NOSTBY;
      end else begin
        mode_d = HSWDT_MODE_HW_ALL;
      end
    end
    // Software start; selects only accepted with the start code
    if (loaded_q && !hw_mode && guard_hit && !started_q) begin
      started_d = 1'b1;
      sel_d = wb_dat_i[7:5];
    end
    // Counter: clears take priority over a tick
    if (!running || stby_halt) begin
      cnt_d = 1'b0;
    end else if (src_clr) begin
      cnt_d = 1'b0;
    end else if (guard_hit && (hw_mode || started_q)) begin
      cnt_d = 1'b0;
    end else if (tick) begin
      cnt_d = 1'b1;
    end
    // Overflow on second tick starts a held reset pulse
    if (running && !stby_halt && !src_clr && !guard_hit && tick && cnt_q) begin
      rst_d = 1'b1;
      rst_cnt_d = HSWDT_RST_PULSE_CYC;
    end else if (rst_cnt_q != 4'h0) begin
      rst_cnt_d = rst_cnt_q - 4'h1;
      rst_d = (rst_cnt_q != 4'h1);
    end
    // Read data; unmapped reads return zero
    if (req) begin
      unique case (wb_adr_i)
        HSWDT_ADR_CONTROL: dat_d = {24'h0, ctl_rd};
        HSWDT_ADR_ID_HIGH: dat_d = {24'h0, id_s[15:8]};
        HSWDT_ADR_ID_LOW: dat_d = {24'h0, id_s[7:0]};
        default: dat_d = 32'h0;
      endcase
    end
  end

  // Registers; software start ends only with srst
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_q <= HSWDT_MODE_SW;
      loaded_q <= 1'b0;
      sel_q <= HSWDT_SEL_RESET;
      started_q <= 1'b0;
      cnt_q <= 1'b0;
      rst_cnt_q <= 4'h0;
      rst_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      mode_q <= mode_d;
      loaded_q <= loaded_d;
      sel_q <= sel_d;
      started_q <= started_d;
      cnt_q <= cnt_d;
      rst_cnt_q <= rst_cnt_d;
      rst_q <= rst_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign watchdog_reset = rst_q;

  // Assertions
  overflow_reset_a: assert property (@(posedge clock) disable iff (srst)
    (running && !stby_halt && !src_clr && !guard_hit && tick && cnt_q)
      |=> watchdog_reset)
    else $error("overflow did not raise watchdog reset");

  first_tick_a: assert property (@(posedge clock) disable iff (srst)
    (running && !stby_halt && !src_clr && !guard_hit && tick && !cnt_q)
      |=> cnt_q && !$rose(watchdog_reset))
    else $error("first tick after clear must not overflow");

  sw_idle_a: assert property (@(posedge clock) disable iff (srst)
    (loaded_q && !hw_mode && !started_q) |=> !cnt_q)
    else $error("counter moved before software start");

  sw_sticky_a: assert property (@(posedge clock) disable iff (srst)
    started_q |=> started_q)
    else $error("software start dropped without reset");

  guard_clear_a: assert property (@(posedge clock) disable iff (srst)
    (guard_hit && (hw_mode || started_q)) |=> !cnt_q)
    else $error("guard code did not clear counter");

  src_clear_a: assert property (@(posedge clock) disable iff (srst)
    src_clr |=> !cnt_q)
    else $error("source clear did not clear counter");

  standby_halt_a: assert property (@(posedge clock) disable iff (srst)
    stby_halt |=> !cnt_q)
    else $error("counter ran while halted in standby");

  hw_select_a: assert property (@(posedge clock) disable iff (srst)
    hw_mode |-> (ctl_rd[7:4] == 4'h3))
    else $error("hardware mode select readback wrong");

  sel_frozen_a: assert property (@(posedge clock) disable iff (srst)
    started_q |=> $stable(sel_q))
    else $error("clock select changed after start");

  bus_ack_a: assert property (@(posedge clock) disable iff (srst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not given in one cycle");

  // Reset pulse, mode latch, stray code and readback checks
  pulse_load_a: assert property (@(posedge clock) disable iff (srst)
    $rose(watchdog_reset) |-> (rst_cnt_q == HSWDT_RST_PULSE_CYC))
    else $error("reset pulse started without a full count");

  pulse_end_a: assert property (@(posedge clock) disable iff (srst)
    (rst_cnt_q == 4'h1 && !(running && !stby_halt && !src_clr && !guard_hit && tick && cnt_q))
      |=> !watchdog_reset)
    else $error("reset pulse did not end on time");

  reset_quiet_a: assert property (@(posedge clock) disable iff (srst)
    !loaded_q |=> !watchdog_reset)
    else $error("reset request raised before counting began");

  stray_code_a: assert property (@(posedge clock) disable iff (srst)
    (wr_ctl && !guard_hit) |=> ($stable(started_q) && $stable(sel_q)))
    else $error("stray guard code changed activation state");

  mode_hold_a: assert property (@(posedge clock) disable iff (srst)
    loaded_q |=> $stable(mode_q))
    else $error("activation mode changed after latch");

  mode_decode_a: assert property (@(posedge clock) disable iff (srst)
    (!loaded_q && id_s == HSWDT_ID_STANDBY_OFF) |=> (mode_q == HSWDT_MODE_HW_NOSTBY))
    else $error("standby-halt selection ID not decoded");

  hw_start_a: assert property (@(posedge clock) disable iff (srst)
    (!loaded_q && id_s != HSWDT_ID_SOFTWARE) |=> (hw_mode && running))
    else $error("hardware watchdog not running after reset release");

  id_read_a: assert property (@(posedge clock) disable iff (srst)
    (req && !wb_we_i && wb_adr_i == HSWDT_ADR_ID_HIGH)
      |=> (wb_dat_o == {24'h0, $past(id_s[15:8])}))
    else $error("selection ID high readback wrong");

  unmapped_read_a: assert property (@(posedge clock) disable iff (srst)
    (req && wb_adr_i != HSWDT_ADR_CONTROL && wb_adr_i != HSWDT_ADR_ID_HIGH
      && wb_adr_i != HSWDT_ADR_ID_LOW) |=> (wb_dat_o == 32'h0))
    else $error("unmapped read returned nonzero data");

endmodule : hswdt_top
`default_nettype wire

// File: tb/test_hw_sw_watchdog_timer.sv
// Self-checking bench for the watchdog top: registers over Wishbone classic,
// tap pulses, source clears, standby and selection IDs driven from here.
// Assumes the hswdt_pkg package is compiled first; no partner model is used.
`timescale 1ns/100ps
`default_nettype none
// Compare two values and count the outcome
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_hw_sw_watchdog_timer
  import hswdt_pkg::*;
;
  logic clock = 1'b0; // 100 MHz bench clock
  logic srst = 1'b1; // Synchronous reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus request
  logic [15:0] adr = 16'h0000; // Byte address
  logic [3:0] sel = 4'h0; // Byte enables
  logic [31:0] dat = 32'h0000_0000; // Write data
  logic [31:0] wb_dat_o; // Read data
  logic wb_ack_o; // Bus answer
  logic [4:0] taps_v = 5'h00; // Tap levels, tb21 first
  logic [2:0] clr_v = 3'h0; // Source clears, timebase first
  logic standby = 1'b0; // Standby level
  logic [15:0] sel_id = 16'h0000; // Selection ID pins
  logic watchdog_reset; // Reset request out
  int n_errors = 0; // Mismatches
  int n_tests = 0; // Comparisons
  int rst_cyc = 0; // Cycles with reset request high
  int rst_base = 0; // Count already accounted for
  logic [7:0] q; // Last read byte

  always #5 clock = ~clock;

  // Count reset request cycles; only this process writes the counter
  always @(posedge clock) begin
    if (watchdog_reset === 1'b1) begin
      rst_cyc <= rst_cyc + 1;
    end
  end

  hswdt_top hswdt_top_inst (
    .clock(clock), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tick_taps(hswdt_tick_t'(taps_v)),
    .source_clear(hswdt_srcclr_t'(clr_v)), .standby(standby),
    .select_id_high(sel_id[15:8]), .select_id_low(sel_id[7:0]),
    .watchdog_reset(watchdog_reset)
  );

  // Ends the run in one place
  task automatic stop_test;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    int k;
    k = 0;
    @(posedge clock);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF;
    dat <= {24'h000000, d};
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    r = wb_dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (k >= 50) begin
      n_errors++;
    end
  endtask : wb

  // Re-reset with a given selection ID held stable throughout
  task automatic restart(input logic [15:0] id);
    @(posedge clock);
    sel_id <= id;
    srst <= 1'b1;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (5) @(posedge clock);
    rst_base = rst_cyc;
  endtask : restart

  // One tap rise, each level held well over the two-cycle minimum
  task automatic pulse(input int t);
    @(posedge clock);
    taps_v[t] <= 1'b1;
    repeat (4) @(posedge clock);
    taps_v[t] <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : pulse

  // Count of reset request cycles since the last look
  task automatic rst_seen(output int n);
    repeat (14) @(posedge clock);
    n = rst_cyc - rst_base;
    rst_base = rst_cyc;
  endtask : rst_seen

  // Tap index for a select code; the sub-RC pick bit overrides the rest
  function automatic int tap_of(input logic [2:0] c);
    return c[0] ? 0 : 4 - int'(c[2:1]);
  endfunction : tap_of

  // Source timer that a select code leans on
  function automatic int src_of(input logic [2:0] c);
    return c[0] ? 0 : (c[2] ? 1 : 2);
  endfunction : src_of

  initial begin
    int n, t;
    logic [2:0] c;
    logic [3:0] bad;
    logic [15:0] id;
    void'($urandom(16487));
    // Software mode: every select code, stray guard codes, clears
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      t = tap_of(c);
      bad = 4'($urandom_range(15));
      if (bad == HSWDT_GUARD_CODE) bad = 4'hA;
      restart(HSWDT_ID_SOFTWARE);
      wb(1'b0, HSWDT_ADR_CONTROL, 8'h00, q);
      `CHK(q, 8'h00)
      pulse(t); pulse(t); rst_seen(n);
      `CHK(n, 0)
      wb(1'b1, HSWDT_ADR_CONTROL, {c, 1'b0, bad}, q);
      pulse(t); pulse(t); rst_seen(n);
      `CHK(n, 0)
      wb(1'b1, HSWDT_ADR_CONTROL, {c, 1'b0, HSWDT_GUARD_CODE}, q);
      wb(1'b0, HSWDT_ADR_CONTROL, 8'h00, q);
      `CHK(q, {c, 5'h00})
      pulse(t);
      @(posedge clock) clr_v[src_of(c)] <= 1'b1;
      repeat (4) @(posedge clock);
      clr_v <= 3'h0;
      pulse(t); rst_seen(n);
      `CHK(n, 0)
      wb(1'b1, HSWDT_ADR_CONTROL, {c, 1'b0, HSWDT_GUARD_CODE}, q);
      pulse(t); rst_seen(n);
      `CHK(n, 0)
      pulse((t + 1) % 5); rst_seen(n);
      `CHK(n, 0)
      pulse(t); rst_seen(n);
      `CHK(n, int'(HSWDT_RST_PULSE_CYC))
    end
    // Hardware mode, running in standby too
    id = 16'($urandom);
    if (id[15:1] == 15'h52CB) id = 16'h1234;
    restart(id);
    wb(1'b0, HSWDT_ADR_CONTROL, 8'h00, q);
    `CHK(q, 8'h30)
    wb(1'b0, HSWDT_ADR_ID_HIGH, 8'h00, q);
    `CHK(q, id[15:8])
    wb(1'b0, HSWDT_ADR_ID_LOW, 8'h00, q);
    `CHK(q, id[7:0])
    pulse(0);
    wb(1'b1, HSWDT_ADR_CONTROL, 8'hF5, q);
    wb(1'b0, HSWDT_ADR_CONTROL, 8'h00, q);
    `CHK(q, 8'h30)
    pulse(0); rst_seen(n);
    `CHK(n, 0)
    standby <= 1'b1;
    pulse(0); rst_seen(n);
    standby <= 1'b0;
    `CHK(n, int'(HSWDT_RST_PULSE_CYC))
    // Hardware mode, halted and cleared in standby
    restart(HSWDT_ID_STANDBY_OFF);
    pulse(0);
    standby <= 1'b1;
    pulse(0);
    standby <= 1'b0;
    pulse(0); rst_seen(n);
    `CHK(n, 0)
    pulse(0); rst_seen(n);
    `CHK(n, int'(HSWDT_RST_PULSE_CYC))
    // Unmapped address reads zero
    wb(1'b0, 16'h0004, 8'h00, q);
    `CHK(q, 8'h00)
    stop_test();
  end

  // Hang guard, far beyond the expected few thousand cycles
  initial begin
    #500000;
    n_errors++;
    stop_test();
  end
endmodule : test_hw_sw_watchdog_timer
`undef CHK
`default_nettype wire
